// *** hdl/dbsm_map.svh ***
// Register commands, field positions, reset values and pin counts of the
// diagnostic blanking and short-detection mux block.
// Assumes it is included by bare name from the package and the design modules.
`ifndef DBSM_MAP_SVH
`define DBSM_MAP_SVH

// ----------------------------------------------------------------------------
// Register commands
// ----------------------------------------------------------------------------
`define DBSM_CMD_RD_BLANK    8'h2b
`define DBSM_CMD_WR_BLANK    8'h3b
`define DBSM_CMD_RD_MUX      8'h2c
`define DBSM_CMD_WR_MUX      8'h3c

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define DBSM_BLANK_W         6
`define DBSM_SEL_W           4
`define DBSM_MUX_PLUS_LSB    4
`define DBSM_MUX_MINUS_LSB   0
`define DBSM_MUX_RST         8'hff
`define DBSM_BLANK_RST       6'h00
`define DBSM_SEL_SHIELD      4'hb
`define DBSM_SEL_LAST_SENSOR 4'h9
`define DBSM_NUM_SENSORS     10
`define DBSM_NUM_PATHS       11

`endif

// *** hdl/dbsm_pkg.sv ***
// Types shared by the diagnostic blanking and short-detection mux design.
// Assumes the map header is on the include path.
`include "dbsm_map.svh"

package dbsm_pkg;

  // --------------------------------------------------------------------------
  // Register access carriers
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    logic [7:0] cmd;
    logic [7:0] wdata;
  } dbsm_req_t;

  typedef struct packed {
    logic       valid;
    logic       err;
    logic [7:0] rdata;
  } dbsm_rsp_t;

  typedef struct packed {
    logic [`DBSM_SEL_W-1:0] plus;
    logic [`DBSM_SEL_W-1:0] minus;
  } dbsm_mux_t;

  typedef enum logic [2:0] {
    DBSM_ST_CLEAR   = 3'b001,
    DBSM_ST_COUNT   = 3'b010,
    DBSM_ST_FAULT   = 3'b100
  } dbsm_state_t;

endpackage

// *** hdl/dbsm_sel_decode.sv ***
// One pin-select decoder of the short-detection mux: turns a 4-bit code into
// a one-hot or all-zero pin enable vector (sensor pins 0..9, then the shield sense pin).
// Assumes the select code is a registered value in the clk domain.
`timescale 1ns/1ps
`include "dbsm_map.svh"

module dbsm_sel_decode
  import dbsm_pkg::*;
(
  input  wire logic                         clk,
  input  wire logic                         srst,
  input  wire logic [`DBSM_SEL_W-1:0]       sel,
  output logic      [`DBSM_NUM_PATHS-1:0]   path_en_ff,
  output logic                              connected_ff
);

  // --------------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------------
  function automatic logic [`DBSM_NUM_PATHS-1:0] decode_sel(
    input logic [`DBSM_SEL_W-1:0] code
  );
    logic [`DBSM_NUM_PATHS-1:0] v;
    v = '0;
    if (code <= `DBSM_SEL_LAST_SENSOR) begin
      v[code] = 1'b1;                                  // [RL9]
    end else if (code == `DBSM_SEL_SHIELD) begin
      v[`DBSM_NUM_PATHS-1] = 1'b1;                     // [RL9]
    end
    return v;
  endfunction

  logic [`DBSM_NUM_PATHS-1:0] nxt_path_en;

  always_comb begin
    nxt_path_en = decode_sel(sel);
  end

  // Codes 1010 and 1100..1111 leave the comparator input floating.
  always_ff @(posedge clk) begin
    if (srst) begin
      path_en_ff   <= '0;
      connected_ff <= 1'b0;
    end else begin
      path_en_ff   <= nxt_path_en;                     // [RL12]
      connected_ff <= |nxt_path_en;                    // [RL12]
    end
  end

endmodule

// *** hdl/dbsm_blank_counter.sv ***
// Up/down blanking counter: counts up toward its all-ones maximum while
// a fault is seen on each evaluation strobe and back toward zero otherwise.
// Assumes eval and fault_raw are synchronous single-cycle/level inputs.
`timescale 1ns/1ps
`include "dbsm_map.svh"

module dbsm_blank_counter
  import dbsm_pkg::*;
#(
  parameter int WIDTH = `DBSM_BLANK_W
)
(
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             eval,
  input  wire logic             fault_raw,
  input  wire logic [WIDTH-1:0] terminal,
  output logic      [WIDTH-1:0] count_ff,
  output logic                  reached_ff
);

  // --------------------------------------------------------------------------
  // Counter
  // --------------------------------------------------------------------------
  localparam logic [WIDTH-1:0] MAX_CNT = {WIDTH{1'b1}};

  logic [WIDTH-1:0] nxt_count;

  always_comb begin
    nxt_count = count_ff;
    if (eval) begin
      if (fault_raw && count_ff != MAX_CNT) begin
        nxt_count = count_ff + 1'b1;                   // [RL11]
      end else if (!fault_raw && count_ff != '0) begin
        nxt_count = count_ff - 1'b1;                   // [RL11]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      count_ff <= '0;
    end else begin
      count_ff <= nxt_count;
    end
  end

  // A terminal value of zero reports in any cycle with fault_raw high, with or
  // without an evaluation strobe, so a zero setting means no blanking rather than a permanently raised fault.
  always_ff @(posedge clk) begin
    if (srst) begin
      reached_ff <= 1'b0;
    end else begin
      reached_ff <= fault_raw && (nxt_count >= terminal);   // [RL2]
    end
  end

endmodule

// *** hdl/dbsm_top.sv ***
// Diagnostic blanking and pin-to-pin short-detection mux control block.
// Assumes the serial host port has already decoded a command byte and,
// for writes, a data byte, presented as one-cycle requests on clk.

`timescale 1ns/1ps
`include "dbsm_map.svh"

// Function
// RL1 - Write command 0x3B loads the 6-bit up/down blanking counter setting.
// RL2 - Diagnostic reaches status only once the counter hits the terminal value.
// RL3 - Blanking register reads with 0x2B and writes with 0x3B.
// RL4 - Write command 0x3C sets the short-detection mux selection.
// RL5 - Mux control reads with 0x2C and writes with 0x3C.
// RL6 - Mux control holds two independent 4-bit select fields.
// RL7 - Plus field drives non-inverting input, minus field drives inverting input.
// RL8 - After reset mux control is 0x00FF, every path disconnected.
// RL9 - Codes 0-9 pick sensor pins, 1011 shield sense, others nothing.
// RL10 - 0x2-range commands read contents, matching 0x3-range commands write.
// RL11 - Counter rises per evaluation on fault, falls otherwise, saturating both ends.
// RL12 - An unconnected select leaves the input floating and raises no short fault.
module dbsm_top
  import dbsm_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        srst,
  input  wire dbsm_req_t                   req,
  output dbsm_rsp_t                        rsp_ff,
  input  wire logic                        diag_eval,
  input  wire logic                        short_cmp_out,
  output logic      [`DBSM_NUM_PATHS-1:0]  plus_path_en_ff,
  output logic      [`DBSM_NUM_PATHS-1:0]  minus_path_en_ff,
  output logic                             short_fault_ff,
  output logic      [`DBSM_BLANK_W-1:0]    blank_count_ff
);

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic [`DBSM_BLANK_W-1:0] blank_setting_ff;
  dbsm_mux_t                mux_ff;

  function automatic logic is_cmd(input dbsm_req_t r, input logic [7:0] c);
    return r.valid && (r.cmd == c);
  endfunction

  always_ff @(posedge clk) begin
    if (srst) begin
      blank_setting_ff <= `DBSM_BLANK_RST;
    end else if (is_cmd(req, `DBSM_CMD_WR_BLANK)) begin
      blank_setting_ff <= req.wdata[`DBSM_BLANK_W-1:0];       // [RL1] [RL3]
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mux_ff <= dbsm_mux_t'(`DBSM_MUX_RST);                     // [RL8]
    end else if (is_cmd(req, `DBSM_CMD_WR_MUX)) begin
      mux_ff.plus  <= req.wdata[`DBSM_MUX_PLUS_LSB +: `DBSM_SEL_W];   // [RL4] [RL6]
      mux_ff.minus <= req.wdata[`DBSM_MUX_MINUS_LSB +: `DBSM_SEL_W];  // [RL4] [RL6]
    end
  end

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  // Answers come one cycle after the command. Commands outside this block
  // answer with err set so the host port can route them elsewhere.
  dbsm_rsp_t nxt_rsp;

  always_comb begin
    nxt_rsp = '0;
    if (req.valid) begin
      nxt_rsp.valid = 1'b1;
      case (req.cmd)
        `DBSM_CMD_RD_BLANK: begin
          nxt_rsp.rdata = {2'h0, blank_setting_ff};            // [RL3] [RL10]
        end
        `DBSM_CMD_RD_MUX: begin
          nxt_rsp.rdata = {mux_ff.plus, mux_ff.minus};         // [RL5] [RL10]
        end
        `DBSM_CMD_WR_BLANK, `DBSM_CMD_WR_MUX: begin
          nxt_rsp.rdata = 8'h00;                               // [RL10]
        end
        default: begin
          nxt_rsp.err = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rsp_ff <= '0;
    end else begin
      rsp_ff <= nxt_rsp;
    end
  end

  // --------------------------------------------------------------------------
  // Short-detection mux
  // --------------------------------------------------------------------------
  logic plus_conn;
  logic minus_conn;

  dbsm_sel_decode u_plus_dec (
    .clk          (clk),
    .srst         (srst),
    .sel          (mux_ff.plus),
    .path_en_ff   (plus_path_en_ff),                           // [RL7]
    .connected_ff (plus_conn)
  );

  dbsm_sel_decode u_minus_dec (
    .clk          (clk),
    .srst         (srst),
    .sel          (mux_ff.minus),
    .path_en_ff   (minus_path_en_ff),                          // [RL7]
    .connected_ff (minus_conn)
  );

  // --------------------------------------------------------------------------
  // Blanking and fault reporting
  // --------------------------------------------------------------------------
  // With either comparator input floating the comparator output is
  // meaningless, so it is forced to no-fault before blanking.
  logic fault_raw;
  logic reached;

  always_comb begin
    fault_raw = short_cmp_out && plus_conn && minus_conn;      // [RL12]
  end

  dbsm_blank_counter #(
    .WIDTH (`DBSM_BLANK_W)
  ) u_blank (
    .clk        (clk),
    .srst       (srst),
    .eval       (diag_eval),
    .fault_raw  (fault_raw),
    .terminal   (blank_setting_ff),
    .count_ff   (blank_count_ff),
    .reached_ff (reached)
  );

  dbsm_state_t st_ff;
  dbsm_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      DBSM_ST_CLEAR: begin
        if (fault_raw) nxt_st = DBSM_ST_COUNT;
      end
      DBSM_ST_COUNT: begin
        if (reached) nxt_st = DBSM_ST_FAULT;                   // [RL2]
        else if (blank_count_ff == '0 && !fault_raw) nxt_st = DBSM_ST_CLEAR;
      end
      DBSM_ST_FAULT: begin
        if (blank_count_ff == '0 && !fault_raw) nxt_st = DBSM_ST_CLEAR;
      end
      default: begin
        nxt_st = DBSM_ST_CLEAR;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_ff <= DBSM_ST_CLEAR;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      short_fault_ff <= 1'b0;
    end else begin
      short_fault_ff <= (nxt_st == DBSM_ST_FAULT);             // [RL2]
    end
  end

endmodule

// *** tb/dbsm_checker.sv ***
// Port assertions for the blanking and short-detection mux block.
// Assumes it is bound to dbsm_top and sees only its ports.
`timescale 1ns/1ps
`include "dbsm_map.svh"
module dbsm_checker
  import dbsm_pkg::*;
(
  input wire logic                       clk,
  input wire logic                       srst,
  input wire dbsm_req_t                  req,
  input wire dbsm_rsp_t                  rsp_ff,
  input wire logic                       diag_eval,
  input wire logic                       short_cmp_out,
  input wire logic [`DBSM_NUM_PATHS-1:0] plus_path_en_ff,
  input wire logic [`DBSM_NUM_PATHS-1:0] minus_path_en_ff,
  input wire logic                       short_fault_ff,
  input wire logic [`DBSM_BLANK_W-1:0]   blank_count_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic wr;
  assign wr = req.valid && req.cmd == `DBSM_CMD_WR_MUX;
  // Mirror of the blanking setting, so a raised fault can be held against it.
  logic [`DBSM_BLANK_W-1:0] blank_set;
  always_ff @(posedge clk) begin
    if (srst) begin
      blank_set <= '0;
    end else if (req.valid && req.cmd == `DBSM_CMD_WR_BLANK) begin
      blank_set <= req.wdata[`DBSM_BLANK_W-1:0];
    end
  end
  a_fault_blanked: assert property ($rose(short_fault_ff) |->
    $past(blank_count_ff) >= $past(blank_set, 2)) else $error("fault raised before terminal");
  a_rsp_follows: assert property (req.valid |=> rsp_ff.valid)
    else $error("no answer after a request");
  a_rsp_quiet: assert property (!req.valid |=> !rsp_ff.valid)
    else $error("answer without a request");
  a_err_unknown: assert property (req.valid && !(req.cmd inside {`DBSM_CMD_RD_BLANK,
    `DBSM_CMD_WR_BLANK, `DBSM_CMD_RD_MUX, `DBSM_CMD_WR_MUX}) |=> rsp_ff.err)
    else $error("unknown command not refused");
  a_blank_width: assert property (req.valid && req.cmd == `DBSM_CMD_RD_BLANK
    |=> rsp_ff.rdata[7:6] == 2'b00) else $error("blank read wider than six bits");
  a_plus_pin: assert property (wr && req.wdata[7:4] <= 4'h9
    |=> ##1 plus_path_en_ff == (11'h1 << $past(req.wdata[7:4], 2)))
    else $error("plus select drives wrong pin");
  a_minus_pin: assert property (wr && req.wdata[3:0] <= 4'h9
    |=> ##1 minus_path_en_ff == (11'h1 << $past(req.wdata[3:0], 2)))
    else $error("minus select drives wrong pin");
  a_shield_pin: assert property (wr && req.wdata[3:0] == 4'hb
    |=> ##1 minus_path_en_ff == 11'h400) else $error("shield code not decoded");
  a_none_open: assert property (wr && (req.wdata[3:0] == 4'ha || req.wdata[3:0] > 4'hb)
    |=> ##1 minus_path_en_ff == 11'h0) else $error("unconnected code drives a pin");
  a_count_hold: assert property (!diag_eval |=> $stable(blank_count_ff))
    else $error("counter moved without evaluation");
endmodule
bind dbsm_top dbsm_checker chk_u (.clk(clk), .srst(srst), .req(req), .rsp_ff(rsp_ff),
  .diag_eval(diag_eval), .short_cmp_out(short_cmp_out), .plus_path_en_ff(plus_path_en_ff),
  .minus_path_en_ff(minus_path_en_ff), .short_fault_ff(short_fault_ff),
  .blank_count_ff(blank_count_ff));

// *** tb/dbsm_host.sv ***
// Host model issuing one register command at a time.
// Assumes requests change at falling edges and one answer per request.
`timescale 1ns/1ps
module dbsm_host
  import dbsm_pkg::*;
(
  input  wire logic      clk,
  output dbsm_req_t      req,
  input  wire dbsm_rsp_t rsp
);
  initial req = '0;
  // Released lines carry the inverse of the last value, so a stale one never looks held.
  task automatic xfer(input logic [7:0] c, input logic [7:0] d, output dbsm_rsp_t r);
    @(negedge clk);
    req = '{1'b1, c, d};
    @(negedge clk);
    r = rsp;
    req = '{1'b0, ~c, ~d};
  endtask
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the blanking counter and short-detection mux.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`include "dbsm_map.svh"
module tb_top
  import dbsm_pkg::*;
;
  logic       clk = 0, srst = 1, diag_eval = 0, short_cmp_out = 0, fault;
  logic [10:0] plus_en, minus_en;
  logic [5:0]  count;
  dbsm_req_t  req;
  dbsm_rsp_t  rsp;
  int         bad_count = 0, checked = 0;
  always #2.5 clk = ~clk;
  dbsm_host host_u (.clk(clk), .req(req), .rsp(rsp));
  dbsm_top dut_u (.clk(clk), .srst(srst), .req(req), .rsp_ff(rsp), .diag_eval(diag_eval),
    .short_cmp_out(short_cmp_out), .plus_path_en_ff(plus_en), .minus_path_en_ff(minus_en),
    .short_fault_ff(fault), .blank_count_ff(count));
  // ----
  // Shared tasks
  // ----
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    if (bad_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic rw(input logic [7:0] c, d, x, input logic e);
    dbsm_rsp_t r;
    host_u.xfer(c, d, r);
    chk(r.valid, 1'b1);
    chk(r.err, e);
    chk(r.rdata, x);
  endtask
  task automatic ev(input logic f, input int n);
    repeat (n) begin
      @(negedge clk);
      diag_eval = 1;
      short_cmp_out = f;
    end
    @(negedge clk);
    diag_eval = 0;
  endtask
  task automatic do_rst;
    @(negedge clk);
    srst = 1;
    repeat (20) @(negedge clk);
    srst = 0;
  endtask
  function automatic logic [10:0] pin(input logic [3:0] c);
    return c <= 4'h9 ? 11'h1 << c : (c == 4'hb ? 11'h400 : 11'h0);
  endfunction
  // ----
  // Scenarios
  // ----
  task automatic t_reset;
    rw(`DBSM_CMD_RD_MUX, 8'h00, 8'hff, 1'b0);
    rw(`DBSM_CMD_RD_BLANK, 8'h00, 8'h00, 1'b0);
    chk(plus_en, 11'h0);
    chk(minus_en, 11'h0);
    chk(fault, 1'b0);
    chk(count, 6'h00);
  endtask
  task automatic t_blank;
    rw(`DBSM_CMD_WR_BLANK, 8'hff, 8'h00, 1'b0);
    rw(`DBSM_CMD_RD_BLANK, 8'h00, 8'h3f, 1'b0);
    rw(`DBSM_CMD_WR_BLANK, 8'h2a, 8'h00, 1'b0);
    rw(`DBSM_CMD_RD_BLANK, 8'h00, 8'h2a, 1'b0);
  endtask
  task automatic t_mux;
    logic [3:0] c;
    for (int k = 0; k < 16; k++) begin
      c = k[3:0];
      rw(`DBSM_CMD_WR_MUX, {c, ~c}, 8'h00, 1'b0);
      rw(`DBSM_CMD_RD_MUX, 8'h00, {c, ~c}, 1'b0);
      chk(plus_en, pin(c));
      chk(minus_en, pin(~c));
    end
  endtask
  task automatic t_unknown;
    rw(8'h2d, 8'h00, 8'h00, 1'b1);
    rw(8'h3d, 8'h55, 8'h00, 1'b1);
    rw(`DBSM_CMD_RD_MUX, 8'h00, 8'hf0, 1'b0);
  endtask
  task automatic t_fault;
    rw(`DBSM_CMD_WR_MUX, 8'h01, 8'h00, 1'b0);
    rw(`DBSM_CMD_WR_BLANK, 8'h03, 8'h00, 1'b0);
    ev(1, 2);
    repeat (2) @(negedge clk);
    chk(count, 6'h02);
    chk(fault, 1'b0);
    ev(1, 1);
    repeat (2) @(negedge clk);
    chk(fault, 1'b1);
    ev(0, 2);
    chk(count, 6'h01);
    chk(fault, 1'b1);
    ev(0, 2);
    repeat (2) @(negedge clk);
    chk(count, 6'h00);
    chk(fault, 1'b0);
    ev(1, 66);
    chk(count, 6'h3f);
    rw(`DBSM_CMD_WR_MUX, 8'hf1, 8'h00, 1'b0);
    ev(1, 70);
    repeat (2) @(negedge clk);
    chk(count, 6'h00);
    chk(fault, 1'b0);
    rw(`DBSM_CMD_WR_MUX, 8'h01, 8'h00, 1'b0);
    ev(1, 4);
    repeat (2) @(negedge clk);
    chk(count, 6'h04);
    chk(fault, 1'b1);
  endtask
  initial begin
    do_rst();
    t_reset();
    t_blank();
    t_mux();
    t_unknown();
    t_fault();
    do_rst();
    t_reset();
    close_out();
  end
  // The whole run needs well under ten thousand cycles.
  initial begin
    #100us;
    bad_count++;
    close_out();
  end
endmodule
